/* File: shared/rtc_pkg.sv */
// rtc_pkg: register map, field positions and reset values shared by the
// retimer channel alarm and reset logic.
// assumes: 8-bit register port, four channels behind a channel select register.
`default_nettype none

package rtc_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int RTC_NUM_CH = 4;
   localparam int RTC_NREG   = 14;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] RTC_A_SOFT_RESET = 8'h00;
   localparam logic [7:0] RTC_A_LOSS_CAUSE = 8'h01;
   localparam logic [7:0] RTC_A_PENDING    = 8'h05;
   localparam logic [7:0] RTC_A_RST_OVR    = 8'h0A;
   localparam logic [7:0] RTC_A_EYE_STAT   = 8'h30;
   localparam logic [7:0] RTC_A_EYE_THR    = 8'h32;
   localparam logic [7:0] RTC_A_ALARM_CFG  = 8'h36;
   localparam logic [7:0] RTC_A_CHAN_SEL   = 8'hFF;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int RTC_B_SOFT_RESET = 2;   // in channel_soft_reset
   localparam int RTC_B_OVR_EN     = 3;   // recovery_reset_override_en
   localparam int RTC_B_OVR_FORCE  = 2;   // recovery_reset_force
   localparam int RTC_B_EYE_EN     = 6;   // in refclk_and_alarm_config
   localparam int RTC_B_EYE_FLAG   = 4;   // in eye_alarm_status
   localparam int RTC_B_LOCK_LOSS  = 4;   // in loss_cause_status
   localparam int RTC_B_SIG_LOSS   = 0;   // in loss_cause_status

   // ----------------------------------------------------------------
   // plain read/write channel registers: address, reset value, write mask
   // ----------------------------------------------------------------
   localparam logic [3:0] RTC_I_RST_OVR   = 4'h0;
   localparam logic [3:0] RTC_I_EYE_STAT  = 4'h1;
   localparam logic [3:0] RTC_I_EYE_THR   = 4'h2;
   localparam logic [3:0] RTC_I_ALARM_CFG = 4'h4;
   localparam logic [0:13][7:0] RTC_REG_ADDR = '{8'h0A, 8'h30, 8'h32, 8'h33, 8'h36, 8'h39, 8'h3A,
                                                 8'h3E, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h70};
   localparam logic [0:13][7:0] RTC_REG_RST  = '{8'h00, 8'h00, 8'h11, 8'h88, 8'h31, 8'h00, 8'hA5,
                                                 8'h80, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
   localparam logic [0:13][7:0] RTC_REG_MASK = '{8'h0C, 8'h0B, 8'hFF, 8'hFF, 8'h77, 8'h1F, 8'hFF,
                                                 8'h80, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h80, 8'h07};

endpackage

`default_nettype wire

/* File: design/rtc_channel.sv */
// rtc_channel: one channel's registers, sticky alarm causes and
// recovery reset override.
// assumes: register strobes are one-cycle pulses, sel already decoded.
`timescale 1ns/100ps
`default_nettype none

module rtc_channel
   import rtc_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rstn,
   // register access
   input  wire logic       sel,
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata,
   // recovery and eye monitor status
   input  wire logic       cdr_locked,
   input  wire logic       sig_detect,
   input  wire logic [7:0] heo,
   input  wire logic [7:0] veo,
   // alarm and reset results
   output logic            pending,
   output logic            lock_loss,
   output logic            sig_loss,
   output logic            eye_flag,
   output logic            eye_en,
   output logic            cdr_hold,
   output logic            acq_restart
);

   typedef struct packed {
      logic [0:13][7:0] regs;
      logic             lock_loss;
      logic             sig_loss;
      logic             eye_flag;
      logic             lock_prev;
      logic             sig_prev;
      logic             eye_prev;
      logic             hold;
      logic             restart;
   } rtc_chan_state_t;

   rtc_chan_state_t s_r;
   rtc_chan_state_t s_nxt;

   // address lookup: {hit, index}
   function automatic logic [4:0] rtc_lookup(input logic [7:0] a);
      logic [4:0] res;
      res = 5'h00;
      for (int i = 0; i < RTC_NREG; i++)
         if (RTC_REG_ADDR[i] == a)
            res = {1'b1, i[3:0]};
      return res;
   endfunction

   logic [4:0] lk;
   logic       eye_low;
   logic       eye_cond;
   logic       soft_rst;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_nxt    = s_r;
      lk       = rtc_lookup(addr);
      // eye is judged on the upper nibble of each opening figure
      eye_low  = (heo[7:4] < s_r.regs[RTC_I_EYE_THR][7:4]) || (veo[7:4] < s_r.regs[RTC_I_EYE_THR][3:0]);
      // R5: eye alarm only when enabled
      eye_cond = s_r.regs[RTC_I_ALARM_CFG][RTC_B_EYE_EN] && eye_low;
      soft_rst = sel && wr && (addr == RTC_A_SOFT_RESET) && wdata[RTC_B_SOFT_RESET];
      if (sel && wr && lk[4])
         s_nxt.regs[lk[3:0]] = (s_r.regs[lk[3:0]] & ~RTC_REG_MASK[lk[3:0]]) | (wdata & RTC_REG_MASK[lk[3:0]]);
      // R12: loss causes clear on read
      if (sel && rd && (addr == RTC_A_LOSS_CAUSE))
      begin
         s_nxt.lock_loss = 1'b0;
         s_nxt.sig_loss  = 1'b0;
      end
      // R13: eye flag clears on read
      if (sel && rd && (addr == RTC_A_EYE_STAT))
         s_nxt.eye_flag = 1'b0;
      // R1: whole channel back to defaults, bit never stored
      if (soft_rst)
      begin
         s_nxt.regs      = RTC_REG_RST;
         s_nxt.lock_loss = 1'b0;
         s_nxt.sig_loss  = 1'b0;
         s_nxt.eye_flag  = 1'b0;
      end
      // R4: losses always alarm
      // R8: falling lock or signal sets sticky causes; set beats clear
      if (s_r.lock_prev && !cdr_locked)
         s_nxt.lock_loss = 1'b1;
      if (s_r.sig_prev && !sig_detect)
         s_nxt.sig_loss = 1'b1;
      // R7: edge of the eye condition so a read really clears it
      if (eye_cond && !s_r.eye_prev)
         s_nxt.eye_flag = 1'b1;
      s_nxt.lock_prev = cdr_locked;
      s_nxt.sig_prev  = sig_detect;
      s_nxt.eye_prev  = eye_cond;
      // R2: force holds recovery only while override enabled
      s_nxt.hold = s_nxt.regs[RTC_I_RST_OVR][RTC_B_OVR_EN] && s_nxt.regs[RTC_I_RST_OVR][RTC_B_OVR_FORCE];
      // R3: release restarts acquisition when a signal is present
      s_nxt.restart = s_r.hold && !s_nxt.hold && sig_detect;
   end

   // state register
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         s_r      <= '0;
         s_r.regs <= RTC_REG_RST;
      end
      else
         s_r <= s_nxt;
   end

   // ----------------------------------------------------------------
   // read data and outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      case (addr)
         RTC_A_SOFT_RESET: rdata = 8'h00;
         RTC_A_LOSS_CAUSE: rdata = {3'h0, s_r.lock_loss, 3'h0, s_r.sig_loss};
         RTC_A_EYE_STAT:   rdata = s_r.regs[RTC_I_EYE_STAT] | {3'h0, s_r.eye_flag, 4'h0};
         default:          rdata = lk[4] ? s_r.regs[lk[3:0]] : 8'h00;
      endcase
   end

   // R16: pending follows the sticky causes only
   assign pending     = s_r.lock_loss || s_r.sig_loss || s_r.eye_flag;
   assign lock_loss   = s_r.lock_loss;
   assign sig_loss    = s_r.sig_loss;
   assign eye_flag    = s_r.eye_flag;
   assign eye_en      = s_r.regs[RTC_I_ALARM_CFG][RTC_B_EYE_EN];
   assign cdr_hold    = s_r.hold;
   assign acq_restart = s_r.restart;

endmodule

`default_nettype wire

/* File: design/rtc_alarm_top.sv */
// rtc_alarm_top: four-channel alarm and reset logic of the retimer,
// shared registers, channel selection and the open-drain alarm line.
// assumes: a serial-bus front end delivers one-cycle read/write strobes
// with an 8-bit address; a read answer is taken one cycle later.
`timescale 1ns/100ps
`default_nettype none

// What this block and its controller do
// R1: channel reset bit restores defaults, self-clears
// R2: override enable plus force holds recovery
// R3: release force restarts acquisition if signal
// R4: lock loss or signal loss always alarms
// R5: enabled eye alarm fires below thresholds
// R6: any alarm pulls shared line low
// R7: eye alarm sets eye status bit
// R8: lock loss bit 4, signal loss bit 0
// R9: shared register shows pending channels
// R10: controller reads pending flags of all devices
// R11: controller selects channel before status reads
// R12: loss cause register clears on read
// R13: eye status bit clears on read
// R14: all causes cleared releases the line
// R15: controller services next device if still low
// R16: causes sticky until read; flags follow
module rtc_alarm_top
   import rtc_pkg::*;
#(
   parameter int NCH = RTC_NUM_CH
)
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rstn,
   // register port
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   output logic      [7:0]       reg_rdata,
   output logic                  reg_rvalid,
   // per-channel recovery and eye monitor status
   input  wire logic [NCH-1:0]   cdr_locked,
   input  wire logic [NCH-1:0]   sig_detect,
   input  wire logic [NCH*8-1:0] heo,
   input  wire logic [NCH*8-1:0] veo,
   // per-channel recovery control
   output logic      [NCH-1:0]   cdr_hold,
   output logic      [NCH-1:0]   acq_restart,
   // open-drain alarm line
   input  wire logic             alarm_line_i,
   output logic                  alarm_line_o,
   output logic                  alarm_line_oe
);

   typedef struct packed {
      logic [7:0] chan_sel;
      logic [7:0] rdata;
      logic       rvalid;
   } rtc_top_state_t;

   rtc_top_state_t s_r;
   rtc_top_state_t s_nxt;

   logic [NCH-1:0] ch_sel;
   logic [7:0]     ch_rdata [NCH];
   logic [NCH-1:0] pending;
   logic [NCH-1:0] lock_loss;
   logic [NCH-1:0] sig_loss;
   logic [NCH-1:0] eye_flag;
   logic [NCH-1:0] eye_en;
   logic [1:0]     cur_ch;

   // ----------------------------------------------------------------
   // channel select decode
   // ----------------------------------------------------------------
   // R11: only the selected channel sees channel accesses
   assign cur_ch = s_r.chan_sel[1:0];

   always_comb
   begin
      ch_sel = '0;
      if ((reg_addr != RTC_A_CHAN_SEL) && (reg_addr != RTC_A_PENDING))
         ch_sel[cur_ch] = 1'b1;
   end

   // ----------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_ch
         rtc_channel u_ch
         (
            .clock       (clock),
            .rstn        (rstn),
            .sel         (ch_sel[g]),
            .wr          (reg_wr),
            .rd          (reg_rd),
            .addr        (reg_addr),
            .wdata       (reg_wdata),
            .rdata       (ch_rdata[g]),
            .cdr_locked  (cdr_locked[g]),
            .sig_detect  (sig_detect[g]),
            .heo         (heo[g*8 +: 8]),
            .veo         (veo[g*8 +: 8]),
            .pending     (pending[g]),
            .lock_loss   (lock_loss[g]),
            .sig_loss    (sig_loss[g]),
            .eye_flag    (eye_flag[g]),
            .eye_en      (eye_en[g]),
            .cdr_hold    (cdr_hold[g]),
            .acq_restart (acq_restart[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // shared registers and read answer
   // ----------------------------------------------------------------
   // read data is captured before the clear-on-read takes effect
   always_comb
   begin
      s_nxt        = s_r;
      s_nxt.rvalid = reg_rd;
      if (reg_wr && (reg_addr == RTC_A_CHAN_SEL))
         s_nxt.chan_sel = reg_wdata;
      if (reg_rd)
      begin
         case (reg_addr)
            // R9: one flag per channel with a pending cause
            RTC_A_PENDING:  s_nxt.rdata = {{(8-NCH){1'b0}}, pending};
            RTC_A_CHAN_SEL: s_nxt.rdata = s_r.chan_sel;
            default:        s_nxt.rdata = ch_rdata[cur_ch];
         endcase
      end
   end

   // state register
   always_ff @(posedge clock)
   begin
      if (!rstn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign reg_rdata  = s_r.rdata;
   assign reg_rvalid = s_r.rvalid;

   // ----------------------------------------------------------------
   // alarm line
   // ----------------------------------------------------------------
   // R6: drive low while anything pending; line is wire-ANDed outside
   // R14: released as soon as every cause is read away
   assign alarm_line_o  = 1'b0;
   assign alarm_line_oe = |pending;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   // pending-flag read answers with the flags of the read cycle
   // R9: pending flags readback
   property p_pending_read;
      logic [NCH-1:0] f;
      (reg_rd && reg_addr == RTC_A_PENDING, f = pending) |=> reg_rvalid && reg_rdata[NCH-1:0] == f;
   endproperty
   a_pending_read: assert property (p_pending_read) else $error("pending flags read back wrong"); // R9

   // R14: line released when nothing pending
   property p_line_release;
      (pending == '0) |-> !alarm_line_oe;
   endproperty
   a_line_release: assert property (p_line_release) else $error("alarm line driven with nothing pending"); // R14

   // self-clearing reset bit always reads zero
   // R1: reset bit reads back zero
   property p_soft_reset_reads_zero;
      (reg_rd && reg_addr == RTC_A_SOFT_RESET && ch_sel != '0) |=> reg_rdata[RTC_B_SOFT_RESET] == 1'b0;
   endproperty
   a_soft_reset_reads_zero: assert property (p_soft_reset_reads_zero) else $error("reset bit did not self-clear"); // R1

   generate
      for (g = 0; g < NCH; g++)
      begin : g_chk
         sequence s_wr(logic [7:0] a);
            reg_wr && ch_sel[g] && reg_addr == a;
         endsequence

         // R1: channel reset drops the recovery hold
         property p_soft_reset;
            s_wr(RTC_A_SOFT_RESET) ##0 reg_wdata[RTC_B_SOFT_RESET] |=> !cdr_hold[g] && !eye_en[g];
         endproperty
         a_soft_reset: assert property (p_soft_reset) else $error("channel reset left state"); // R1

         // R2: both bits in one write hold recovery
         property p_force_hold;
            s_wr(RTC_A_RST_OVR) ##0 (reg_wdata[3:2] == 2'h3) |=> cdr_hold[g] [*1] ##1 1'b1;
         endproperty
         a_force_hold: assert property (p_force_hold) else $error("override write did not hold recovery"); // R2

         // R2: force alone never holds
         property p_force_needs_en;
            s_wr(RTC_A_RST_OVR) ##0 !reg_wdata[RTC_B_OVR_EN] |=> !cdr_hold[g];
         endproperty
         a_force_needs_en: assert property (p_force_needs_en) else $error("hold without override enable"); // R2

         // R3: release with signal restarts acquisition
         property p_restart;
            $fell(cdr_hold[g]) && $past(sig_detect[g]) |-> acq_restart[g] ##1 !acq_restart[g];
         endproperty
         a_restart: assert property (p_restart) else $error("no single restart pulse on release"); // R3

         // R4: lock loss pulls the line low next cycle
         property p_lock_alarm;
            $fell(cdr_locked[g]) |=> lock_loss[g] && pending[g] && alarm_line_oe;
         endproperty
         a_lock_alarm: assert property (p_lock_alarm) else $error("lock loss did not alarm"); // R4

         // R8: signal loss sets its own bit
         property p_sig_alarm;
            $fell(sig_detect[g]) |=> sig_loss[g];
         endproperty
         a_sig_alarm: assert property (p_sig_alarm) else $error("signal loss bit not set"); // R8

         // R6: any pending channel drives the line
         property p_line_low;
            pending[g] |-> alarm_line_oe && !alarm_line_o;
         endproperty
         a_line_low: assert property (p_line_low) else $error("pending channel not driving alarm"); // R6

         // R5: eye flag only rises while enabled
         property p_eye_enabled;
            $rose(eye_flag[g]) |-> $past(eye_en[g]);
         endproperty
         a_eye_enabled: assert property (p_eye_enabled) else $error("eye alarm while disabled"); // R5

         // R12: loss causes clear on read unless a new loss
         property p_loss_clear;
            reg_rd && ch_sel[g] && reg_addr == RTC_A_LOSS_CAUSE && cdr_locked[g] && sig_detect[g]
               |=> !lock_loss[g] && !sig_loss[g];
         endproperty
         a_loss_clear: assert property (p_loss_clear) else $error("loss causes not cleared by read"); // R12

         // R13: eye flag read clears it, answer shows old value
         property p_eye_clear;
            logic f;
            (reg_rd && ch_sel[g] && reg_addr == RTC_A_EYE_STAT && !eye_en[g], f = eye_flag[g])
               |=> !eye_flag[g] && reg_rdata[RTC_B_EYE_FLAG] == f;
         endproperty
         a_eye_clear: assert property (p_eye_clear) else $error("eye flag read did not clear"); // R13

         // R16: lock loss cause stays until read or channel reset
         property p_sticky;
            lock_loss[g] && !(reg_rd && ch_sel[g] && reg_addr == RTC_A_LOSS_CAUSE)
               && !(reg_wr && ch_sel[g] && reg_addr == RTC_A_SOFT_RESET) |=> lock_loss[g];
         endproperty
         a_sticky: assert property (p_sticky) else $error("lock loss cause dropped unread"); // R16
      end
   endgenerate

endmodule

`default_nettype wire

/* File: test/rtc_line_model.sv */
// rtc_line_model: shared open-drain alarm line with its pull-up and one
// more device wired onto it.
// assumes: an enable is high while its device pulls the line.
`timescale 1ns/100ps
`default_nettype none

module rtc_line_model
(
   // pulling devices
   input  wire logic dut_oe,
   input  wire logic dut_o,
   input  wire logic peer_oe,
   // resolved wire level
   output logic      line
);
   // wired-and: any puller wins, pull-up otherwise
   // shared line
   assign line = ((dut_oe && !dut_o) || peer_oe) ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

/* File: test/rtc_alarm_top_test.sv */
// rtc_alarm_top_test: register-call tests of the alarm and reset block.
// assumes: a read answer is sampled on the falling edge after rvalid rises.
`timescale 1ns/100ps
`default_nettype none

module rtc_alarm_top_test
   import rtc_pkg::*;
;
   logic        clock, rstn, reg_wr, reg_rd, reg_rvalid, line, oe, od, peer_oe;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [3:0]  locked, sig, hold, restart;
   logic [31:0] heo, veo;
   int          errors, checks;
   int          restarts = 0;

   // selects what bit_chk looks at once settled
   localparam int W_LINE = 0;
   localparam int W_HOLD = 1;

   // free-running clock, 8 ns
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   rtc_alarm_top i_dut (.clock(clock), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .cdr_locked(locked), .sig_detect(sig), .heo(heo), .veo(veo), .cdr_hold(hold),
      .acq_restart(restart), .alarm_line_i(line), .alarm_line_o(od), .alarm_line_oe(oe));

   rtc_line_model i_line (.dut_oe(oe), .dut_o(od), .peer_oe(peer_oe), .line(line));

   // one-cycle restart pulses would be missed by polling, so count them
   always @(posedge clock)
   begin
      if (restart[0] === 1'b1)
         restarts <= restarts + 1;
   end

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // read one byte and compare; a missing answer ends the run
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
      int i;
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      for (i = 0; i < 4; i++)
      begin
         @(negedge clock);
         if (reg_rvalid === 1'b1)
            break;
      end
      if (i == 4)
      begin
         errors++;
         $display("MISMATCH rvalid of %s expected 1 seen 0", n);
         close_out();
      end
      chk(n, e, reg_rdata);
   endtask

   // settle a few cycles, then look at a single-bit output; the value
   // is fetched after the wait, a by-value argument would be stale
   task automatic bit_chk(input string n, input logic e, input int w);
      logic g;
      repeat (3) @(posedge clock);
      @(negedge clock);
      g = (w == W_HOLD) ? hold[0] : line;
      chk(n, {7'h00, e}, {7'h00, g});
   endtask

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial
   begin
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      locked = 4'hF;
      sig = 4'hF;
      heo = 32'hFFFFFFFF;
      veo = 32'hFFFFFFFF;
      peer_oe = 1'b0;
      errors = 0;
      checks = 0;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      // defaults of every plain register, unmapped place and line idle
      for (int k = 0; k < RTC_NREG; k++)
         rdc(RTC_REG_ADDR[k], RTC_REG_RST[k], "reset value");
      rdc(8'h02, 8'h00, "unmapped");
      rdc(RTC_A_PENDING, 8'h00, "pending idle");
      bit_chk("line idle", 1'b1, W_LINE);
      wr(RTC_A_EYE_STAT, 8'hFF);
      rdc(RTC_A_EYE_STAT, 8'h0B, "eye stat mask");
      $display("test reset done");
      // short lock drop on channel 1, gone before service
      @(posedge clock);
      locked[1] <= 1'b0;
      @(posedge clock);
      locked[1] <= 1'b1;
      bit_chk("line low", 1'b0, W_LINE);
      rdc(RTC_A_PENDING, 8'h02, "pending ch1");
      wr(RTC_A_CHAN_SEL, 8'h01);
      rdc(RTC_A_LOSS_CAUSE, 8'h10, "lock loss");
      rdc(RTC_A_LOSS_CAUSE, 8'h00, "cause cleared");
      rdc(RTC_A_PENDING, 8'h00, "pending cleared");
      bit_chk("line released", 1'b1, W_LINE);
      // both causes on channel 2 while a peer also pulls
      @(posedge clock);
      locked[2] <= 1'b0;
      sig[2] <= 1'b0;
      peer_oe <= 1'b1;
      wr(RTC_A_CHAN_SEL, 8'h02);
      rdc(RTC_A_LOSS_CAUSE, 8'h11, "both causes");
      bit_chk("peer holds line", 1'b0, W_LINE);
      @(posedge clock);
      peer_oe <= 1'b0;
      locked[2] <= 1'b1;
      sig[2] <= 1'b1;
      bit_chk("line free", 1'b1, W_LINE);
      $display("test loss done");
      // eye alarm on channel 3, first disabled then enabled
      wr(RTC_A_CHAN_SEL, 8'h03);
      veo[31:24] <= 8'h00;
      bit_chk("eye disabled", 1'b1, W_LINE);
      wr(RTC_A_ALARM_CFG, 8'h71);
      bit_chk("eye line low", 1'b0, W_LINE);
      rdc(RTC_A_PENDING, 8'h08, "pending ch3");
      // channel 3 plain bits are still at reset, only the flag shows
      rdc(RTC_A_EYE_STAT, 8'h10, "eye flag");
      rdc(RTC_A_EYE_STAT, 8'h00, "eye cleared");
      bit_chk("eye line free", 1'b1, W_LINE);
      // horizontal opening below its limit alarms too
      @(posedge clock);
      veo[31:24] <= 8'hFF;
      @(posedge clock);
      heo[31:24] <= 8'h00;
      rdc(RTC_A_EYE_STAT, 8'h10, "heo flag");
      @(posedge clock);
      heo[31:24] <= 8'hFF;
      $display("test eye done");
      // recovery hold and release on channel 0
      wr(RTC_A_CHAN_SEL, 8'h00);
      wr(RTC_A_RST_OVR, 8'h04);
      bit_chk("force alone", 1'b0, W_HOLD);
      wr(RTC_A_RST_OVR, 8'h0C);
      bit_chk("hold set", 1'b1, W_HOLD);
      rdc(RTC_A_ALARM_CFG, 8'h31, "regs kept");
      chk("no restart yet", 8'h00, 8'(restarts));
      wr(RTC_A_RST_OVR, 8'h08);
      bit_chk("hold dropped", 1'b0, W_HOLD);
      chk("one restart", 8'h01, 8'(restarts));
      $display("test override done");
      // channel reset restores defaults and self-clears
      wr(8'h33, 8'h5A);
      rdc(8'h33, 8'h5A, "thr written");
      wr(RTC_A_SOFT_RESET, 8'h04);
      rdc(8'h33, 8'h88, "thr default");
      rdc(RTC_A_RST_OVR, 8'h00, "ovr default");
      rdc(RTC_A_SOFT_RESET, 8'h00, "self clear");
      $display("test soft reset done");
      close_out();
   end
endmodule

`default_nettype wire
